/* inc/pd_eeprom_map.svh */
// Purpose: constants of the presence-detect eeprom slave
// Assumes: included by bare name
// Notes:   field positions, type codes, counts, reset values and timing figures
`ifndef PD_EEPROM_MAP_SVH
`define PD_EEPROM_MAP_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define PDE_CLK_FREQ_HZ        10000000
`define PDE_INTERNAL_PROGRAM_MS 10

// ----------------------------------------
// select code fields
// ----------------------------------------
`define PDE_TYPE_MSB   7
`define PDE_TYPE_LSB   4
`define PDE_STRAP_MSB  3
`define PDE_STRAP_LSB  1
`define PDE_RW_BIT     0
`define PDE_TYPE_MEM   4'ha
`define PDE_TYPE_PROT  4'h6

// ----------------------------------------
// counts and reset values
// ----------------------------------------
`define PDE_BYTE_BITS  4'h8
`define PDE_ADDR_RST   8'h00
`define PDE_PROT_RST   8'h00
`define PDE_PIN_RST    6'h38

`endif

/* inc/pd_eeprom_pkg.sv */
// Purpose: types of the presence-detect eeprom slave
// Assumes: nothing
// Notes:   pins_t is the carrier of the sampled pins
package pd_eeprom_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEVSEL,
        ST_ADDR,
        ST_WDATA,
        ST_RDATA,
        ST_WSTOP
    } state_t;

    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       wc_n;
        logic [2:0] strap;
    } pins_t;

endpackage : pd_eeprom_pkg

/* rtl/pin_sync3.sv */
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to i_clk
// Notes:   output moves only once stages two and three agree
`timescale 1ns/10ps
`default_nettype none

module pin_sync3 #(
    parameter int unsigned     WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // pins
    input  wire logic [WIDTH-1:0] i_async,
    // filtered levels
    output logic      [WIDTH-1:0] o_level
);

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    s1_reg  <= RST_VAL[gi];
                    s2_reg  <= RST_VAL[gi];
                    s3_reg  <= RST_VAL[gi];
                    lvl_reg <= RST_VAL[gi];
                end else begin
                    s1_reg <= i_async[gi];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        lvl_reg <= s3_reg;
                    end
                end
            end
            assign o_level[gi] = lvl_reg;
        end
    endgenerate

endmodule : pin_sync3

`default_nettype wire

/* rtl/program_timer.sv */
// Purpose: self-timed internal program cycle
// Assumes: i_start is a one-cycle pulse
// Notes:   o_busy is high for CYCLES clocks after the pulse
`timescale 1ns/10ps
`default_nettype none

module program_timer #(
    parameter int unsigned CYCLES = 100000
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // control
    input  wire logic i_start,
    // status
    output logic      o_busy
);

    localparam int unsigned CNT_W = $clog2(CYCLES + 1);

    logic [CNT_W-1:0] cnt_reg;
    logic             busy_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
        end else if (i_start) begin
            cnt_reg  <= CNT_W'(CYCLES);
            busy_reg <= 1'b1;
        end else if (busy_reg) begin
            cnt_reg  <= cnt_reg - CNT_W'(1);
            busy_reg <= (cnt_reg != CNT_W'(1));
        end
    end

    assign o_busy = busy_reg;

endmodule : program_timer

`default_nettype wire

/* rtl/presence_detect_eeprom_slave.sv */
// Purpose: two-wire slave of the module's presence-detect eeprom
// Assumes: i_clk at 10 MHz, i_scl made by the bus master
// Notes:   open-drain data pin; no reset pin on the bus side
//
// Notes on behaviour
// - transmitter releases after eight bits; receiver acks
// - acknowledge matching select code after start
// - acknowledge every received write byte while write-control is low
// - send eight bits, release, sample master ack
// - master ack without stop sends next byte
// - no ack ends reads; wait for stop
// - select code arrives msb first
// - memory code 1010, straps, direction bit
// - protection register code 0110, same fields
// - current read returns byte at pointer
// - random read uses dummy write then restart
// - sequential read continues while master acks
// - writes need write-control low, page sixteen
// - program cycle after write stop ignores bus
// - data changes only while clock low
// - start is data fall with clock high
// - stop is data rise, returns standby
`timescale 1ns/10ps
`default_nettype none

`include "pd_eeprom_map.svh"

module presence_detect_eeprom_slave #(
    parameter int unsigned PROG_CYCLES =
        `PDE_INTERNAL_PROGRAM_MS * (`PDE_CLK_FREQ_HZ / 1000),
    parameter int unsigned ADDR_W      = 8,
    parameter int unsigned PAGE_W      = 4
) (
    // system clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // two-wire bus
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda,
    output logic      o_sda_oe_n,
    // straps and write control
    input  wire logic i_wc_n,
    input  wire logic i_strap_addr_bit2,
    input  wire logic i_strap_addr_bit1,
    input  wire logic i_strap_addr_bit0,
    // status
    output logic      o_busy
);

    // ----------------------------------------
    // pin sampling
    // ----------------------------------------
    pd_eeprom_pkg::pins_t pin_raw;
    pd_eeprom_pkg::pins_t pin_f;

    assign pin_raw = '{scl: i_scl, sda: i_sda, wc_n: i_wc_n,
                       strap: {i_strap_addr_bit2, i_strap_addr_bit1,
                               i_strap_addr_bit0}};

    pin_sync3 #(
        .WIDTH   (6),
        .RST_VAL (`PDE_PIN_RST)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (pin_raw),
        .o_level (pin_f)
    );

    // ----------------------------------------
    // link domain: bit capture on scl
    // ----------------------------------------
    // rx_shift_reg changes only at scl rise; the system domain reads it
    // only after the filtered scl has fallen, so it is stable by then
    logic [7:0] rx_shift_reg;

    always_ff @(posedge i_scl) begin
        rx_shift_reg <= {rx_shift_reg[6:0], i_sda};
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    pd_eeprom_pkg::state_t state_reg;
    pd_eeprom_pkg::state_t state_next;

    logic              scl_prev_reg;
    logic              sda_prev_reg;
    logic [3:0]        bit_cnt_reg;
    logic              ack_slot_reg;
    logic              master_ack_reg;
    logic              prot_sel_reg;
    logic              wrote_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0]        prot_reg;
    logic [7:0]        tx_reg;
    logic              oe_n_reg;
    logic              oe_n_next;
    logic              sda_reg;
    logic [7:0]        mem [0:(1<<ADDR_W)-1];

    // ----------------------------------------
    // event decode
    // ----------------------------------------
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;
    logic              byte_done;
    logic              ack_end;
    logic              type_mem;
    logic              type_prot;
    logic              strap_ok;
    logic              sel_match;
    logic              wr_ok;
    logic              wr_take;
    logic              prog_start;
    logic [ADDR_W-1:0] page_next;
    logic [7:0]        rd_byte;

    assign scl_rise  = pin_f.scl & ~scl_prev_reg;
    assign scl_fall  = ~pin_f.scl & scl_prev_reg;
    assign start_det = pin_f.scl & scl_prev_reg & sda_prev_reg & ~pin_f.sda;
    assign stop_det  = pin_f.scl & scl_prev_reg & ~sda_prev_reg & pin_f.sda;
    assign byte_done = scl_fall & ~ack_slot_reg & (bit_cnt_reg == `PDE_BYTE_BITS);
    assign ack_end   = scl_fall & ack_slot_reg;

    assign type_mem  = rx_shift_reg[`PDE_TYPE_MSB:`PDE_TYPE_LSB] == `PDE_TYPE_MEM;
    assign type_prot = rx_shift_reg[`PDE_TYPE_MSB:`PDE_TYPE_LSB] == `PDE_TYPE_PROT;
    assign strap_ok  = rx_shift_reg[`PDE_STRAP_MSB:`PDE_STRAP_LSB] == pin_f.strap;
    assign sel_match = (type_mem | type_prot) & strap_ok;
    assign wr_ok     = ~pin_f.wc_n;
    assign wr_take   = byte_done & (state_reg == pd_eeprom_pkg::ST_WDATA) & wr_ok;
    assign prog_start = stop_det & wrote_reg;

    // page writes roll over inside the sixteen-byte page
    assign page_next = {addr_reg[ADDR_W-1:PAGE_W],
                        addr_reg[PAGE_W-1:0] + PAGE_W'(1)};
    assign rd_byte   = prot_sel_reg ? prot_reg : mem[addr_reg];

    // ----------------------------------------
    // next state and data pin drive
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        oe_n_next  = oe_n_reg;
        if (stop_det) begin
            state_next = pd_eeprom_pkg::ST_IDLE;
            oe_n_next  = 1'b1;
        end else if (start_det) begin
            // a busy device treats the whole frame as foreign
            state_next = o_busy ? pd_eeprom_pkg::ST_IDLE : pd_eeprom_pkg::ST_DEVSEL;
            oe_n_next  = 1'b1;
        end else if (byte_done) begin
            unique case (state_reg)
                pd_eeprom_pkg::ST_DEVSEL: begin
                    if (sel_match) begin
                        oe_n_next  = 1'b0;
                        state_next = rx_shift_reg[`PDE_RW_BIT] ?
                            pd_eeprom_pkg::ST_RDATA : pd_eeprom_pkg::ST_ADDR;
                    end else begin
                        state_next = pd_eeprom_pkg::ST_IDLE;
                    end
                end
                pd_eeprom_pkg::ST_ADDR: begin
                    oe_n_next  = 1'b0;
                    state_next = pd_eeprom_pkg::ST_WDATA;
                end
                pd_eeprom_pkg::ST_WDATA: begin
                    if (wr_ok) begin
                        oe_n_next = 1'b0;
                    end else begin
                        state_next = pd_eeprom_pkg::ST_WSTOP;
                    end
                end
                pd_eeprom_pkg::ST_RDATA: oe_n_next = 1'b1;
                pd_eeprom_pkg::ST_IDLE, pd_eeprom_pkg::ST_WSTOP: oe_n_next = 1'b1;
            endcase
        end else if (ack_end) begin
            oe_n_next = 1'b1;
            if (state_reg == pd_eeprom_pkg::ST_RDATA) begin
                if (master_ack_reg) begin
                    oe_n_next = rd_byte[7];
                end else begin
                    state_next = pd_eeprom_pkg::ST_WSTOP;
                end
            end
        end else if (scl_fall && state_reg == pd_eeprom_pkg::ST_RDATA) begin
            oe_n_next = tx_reg[6];
        end
    end

    // ----------------------------------------
    // bit framing
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg    <= pd_eeprom_pkg::ST_IDLE;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            bit_cnt_reg  <= 4'h0;
            ack_slot_reg <= 1'b0;
            oe_n_reg     <= 1'b1;
            sda_reg      <= 1'b0;
        end else begin
            state_reg    <= state_next;
            scl_prev_reg <= pin_f.scl;
            sda_prev_reg <= pin_f.sda;
            oe_n_reg     <= oe_n_next;
            sda_reg      <= 1'b0;
            if (start_det || stop_det) begin
                bit_cnt_reg  <= 4'h0;
                ack_slot_reg <= 1'b0;
            end else if (byte_done) begin
                bit_cnt_reg  <= 4'h0;
                ack_slot_reg <= 1'b1;
            end else if (ack_end) begin
                bit_cnt_reg  <= 4'h1;
                ack_slot_reg <= 1'b0;
            end else if (scl_fall) begin
                bit_cnt_reg  <= bit_cnt_reg + 4'h1;
            end
        end
    end

    // ----------------------------------------
    // pointer, protection byte and transmit shifter
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            master_ack_reg <= 1'b0;
            prot_sel_reg   <= 1'b0;
            wrote_reg      <= 1'b0;
            addr_reg       <= ADDR_W'(`PDE_ADDR_RST);
            prot_reg       <= `PDE_PROT_RST;
            tx_reg         <= 8'h00;
        end else begin
            if (scl_rise && ack_slot_reg) begin
                master_ack_reg <= ~pin_f.sda;
            end
            if (byte_done && state_reg == pd_eeprom_pkg::ST_DEVSEL && sel_match) begin
                prot_sel_reg <= type_prot;
            end
            if (byte_done && state_reg == pd_eeprom_pkg::ST_ADDR) begin
                addr_reg <= rx_shift_reg[ADDR_W-1:0];
            end else if (wr_take) begin
                addr_reg <= page_next;
            end else if (ack_end && state_reg == pd_eeprom_pkg::ST_RDATA && master_ack_reg) begin
                addr_reg <= addr_reg + ADDR_W'(1);
            end
            if (wr_take && prot_sel_reg) begin
                prot_reg <= rx_shift_reg;
            end
            if (stop_det) begin
                wrote_reg <= 1'b0;
            end else if (wr_take) begin
                wrote_reg <= 1'b1;
            end
            if (ack_end) begin
                tx_reg <= rd_byte;
            end else if (scl_fall) begin
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
    end

    // array has no reset: contents survive a logic reset
    always_ff @(posedge i_clk) begin
        if (wr_take && !prot_sel_reg) begin
            mem[addr_reg] <= rx_shift_reg;
        end
    end

    program_timer #(
        .CYCLES  (PROG_CYCLES)
    ) u_prog (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_start (prog_start),
        .o_busy  (o_busy)
    );

    assign o_sda      = sda_reg;
    assign o_sda_oe_n = oe_n_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    AST_ACK_ON_MATCH: assert property (
        byte_done && state_reg == pd_eeprom_pkg::ST_DEVSEL && sel_match && !stop_det
        |=> !o_sda_oe_n [*1] ##0 ack_slot_reg)
        else $error("no acknowledge after matching select code");
    AST_NO_ACK_MISMATCH: assert property (
        byte_done && state_reg == pd_eeprom_pkg::ST_DEVSEL && !sel_match
        |=> o_sda_oe_n && state_reg == pd_eeprom_pkg::ST_IDLE)
        else $error("acknowledged a foreign select code");
    AST_WRITE_ACK: assert property (
        wr_take |=> !o_sda_oe_n && wrote_reg)
        else $error("write byte not acknowledged");
    AST_READ_RELEASE: assert property (
        byte_done && state_reg == pd_eeprom_pkg::ST_RDATA |=> o_sda_oe_n)
        else $error("data line not released for master acknowledge");
    AST_NACK_ENDS: assert property (
        ack_end && state_reg == pd_eeprom_pkg::ST_RDATA && !master_ack_reg
        |=> o_sda_oe_n && state_reg == pd_eeprom_pkg::ST_WSTOP)
        else $error("read went on after no acknowledge");
    AST_STOP_STANDBY: assert property (
        stop_det |=> state_reg == pd_eeprom_pkg::ST_IDLE && o_sda_oe_n)
        else $error("stop did not return to standby");
    AST_BUSY_AFTER_WRITE: assert property (
        prog_start |=> o_busy [*8])
        else $error("program cycle not started after write stop");
    AST_BUSY_IGNORES: assert property (
        start_det && o_busy |=> state_reg == pd_eeprom_pkg::ST_IDLE)
        else $error("bus answered during program cycle");
    AST_PAGE_WRAP: assert property (
        wr_take && addr_reg[PAGE_W-1:0] == '1
        |=> addr_reg[PAGE_W-1:0] == '0 && $stable(addr_reg[ADDR_W-1:PAGE_W]))
        else $error("page write left its page");
    AST_SDA_SCL_LOW: assert property (
        $changed(o_sda_oe_n) && !$past(start_det) && !$past(stop_det) |-> !pin_f.scl)
        else $error("data line moved while clock high");

    COV_READ_NEXT: cover property (
        ack_end && state_reg == pd_eeprom_pkg::ST_RDATA && master_ack_reg);
    COV_WRITE: cover property (prog_start);
    COV_NACK: cover property (
        ack_end && state_reg == pd_eeprom_pkg::ST_RDATA && !master_ack_reg);
    COV_BUSY_START: cover property (start_det && o_busy);

endmodule : presence_detect_eeprom_slave

`default_nettype wire

/* bench/two_wire_master.sv */
// Purpose: behavioural two-wire bus master driving the eeprom slave
// Assumes: i_link_clk runs at 48 ns; one bus phase is QTR link ticks
// Notes:   o_sda is the level wanted on the wire; 1 means released
`timescale 1ns/10ps
`default_nettype none

module two_wire_master #(
    parameter int unsigned QTR = 16
) (
    // link clock
    input  wire logic i_link_clk,
    // bus
    input  wire logic i_sda,
    output var  logic o_scl,
    output var  logic o_sda
);
    // ----------------------------------------
    // bus phases
    // ----------------------------------------
    // scl stands still high between frames; 4*QTR ticks a bit keeps it near 325 kHz
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic wait_q(input int unsigned n);
        repeat (n * QTR) @(posedge i_link_clk);
        #1;
    endtask : wait_q

    // doubles as repeated start when scl is low
    task automatic start_cond;
        if (o_scl === 1'b0) begin
            wait_q(1);
            o_sda = 1'b1;
            wait_q(1);
            o_scl = 1'b1;
        end
        wait_q(2);
        o_sda = 1'b0;
        wait_q(2);
        o_scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond;
        wait_q(1);
        o_sda = 1'b0;
        wait_q(1);
        o_scl = 1'b1;
        wait_q(2);
        o_sda = 1'b1;
        wait_q(2);
    endtask : stop_cond

    task automatic bit_cycle(input logic b, output logic r);
        wait_q(1);
        o_sda = b;
        wait_q(1);
        o_scl = 1'b1;
        wait_q(1);
        r = i_sda;
        wait_q(1);
        o_scl = 1'b0;
    endtask : bit_cycle

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_cycle(b[i], r);
        bit_cycle(1'b1, r);
        ack = ~r;
    endtask : put_byte

    task automatic get_byte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, r);
            b[i] = r;
        end
        bit_cycle(~ack, r);
    endtask : get_byte
endmodule : two_wire_master

`default_nettype wire

/* bench/presence_detect_eeprom_slave_bench.sv */
// Purpose: self-checking bench of the presence-detect eeprom slave
// Assumes: short program cycle through PROG_CYCLES
// Notes:   wire level is the wired-and of master and device
`timescale 1ns/10ps
`default_nettype none

`include "pd_eeprom_map.svh"

`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); end end

module presence_detect_eeprom_slave_bench;
    localparam int unsigned PROG  = 400;
    localparam logic [2:0]  STRAP = 3'h5;
    localparam logic [3:0]  MEM   = `PDE_TYPE_MEM;
    localparam logic [3:0]  PROT  = `PDE_TYPE_PROT;

    logic i_clk;
    logic i_rst;
    logic link_clk;
    logic i_wc_n;
    logic [2:0] strap;
    wire  scl;
    wire  m_sda;
    wire  o_sda;
    wire  o_sda_oe_n;
    wire  o_busy;
    wire  sda_wire;
    int   error_cnt;
    int   checks;
    int   busy_run;
    int   busy_last;

    // pull-up: released line reads high
    assign sda_wire = m_sda & (o_sda_oe_n | o_sda);

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end

    always @(posedge i_clk) begin
        if (o_busy === 1'b1) busy_run++;
        else if (busy_run != 0) begin
            busy_last = busy_run;
            busy_run  = 0;
        end
    end

    two_wire_master #(.QTR(16)) u_master (
        .i_link_clk (link_clk),
        .i_sda      (sda_wire),
        .o_scl      (scl),
        .o_sda      (m_sda)
    );

    presence_detect_eeprom_slave #(.PROG_CYCLES(PROG), .ADDR_W(8), .PAGE_W(4)) u_dut (
        .i_clk             (i_clk),
        .i_rst             (i_rst),
        .i_scl             (scl),
        .i_sda             (sda_wire),
        .o_sda             (o_sda),
        .o_sda_oe_n        (o_sda_oe_n),
        .i_wc_n            (i_wc_n),
        .i_strap_addr_bit2 (strap[2]),
        .i_strap_addr_bit1 (strap[1]),
        .i_strap_addr_bit0 (strap[0]),
        .o_busy            (o_busy)
    );

    // ----------------------------------------
    // shared bus steps
    // ----------------------------------------
    function automatic logic [7:0] code(input logic [3:0] ty, input logic rw);
        return {ty, STRAP, rw};
    endfunction : code

    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic a;
        u_master.put_byte(b, a);
        `CHK("ack", exp_ack, a);
    endtask : send

    task automatic recv(input logic ack, input logic [7:0] exp);
        logic [7:0] d;
        u_master.get_byte(ack, d);
        `CHK("read data", exp, d);
    endtask : recv

    task automatic wait_idle;
        for (int n = 0; n < 3 * PROG && o_busy !== 1'b0; n++) begin
            @(posedge i_clk);
            #1;
        end
        // one more edge so the run-length monitor has latched the finished run
        @(posedge i_clk);
        #1;
        `CHK("busy end", 1'b0, o_busy);
    endtask : wait_idle

    task automatic rd_at(input logic [3:0] ty, input logic [7:0] a, input logic [7:0] exp);
        u_master.start_cond();
        send(code(ty, 1'b0), 1'b1);
        send(a, 1'b1);
        u_master.start_cond();
        send(code(ty, 1'b1), 1'b1);
        recv(1'b0, exp);
        u_master.stop_cond();
    endtask : rd_at

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_prot;
        rd_at(PROT, 8'h00, `PDE_PROT_RST);
        u_master.start_cond();
        send(code(PROT, 1'b0), 1'b1);
        send(8'h00, 1'b1);
        send(8'h3c, 1'b1);
        u_master.stop_cond();
        wait_idle();
        rd_at(PROT, 8'h00, 8'h3c);
    endtask : t_prot

    task automatic t_byte_write;
        u_master.start_cond();
        send(code(MEM, 1'b0), 1'b1);
        send(8'h40, 1'b1);
        send(8'h5a, 1'b1);
        u_master.stop_cond();
        `CHK("busy", 1'b1, o_busy);
        u_master.start_cond();
        send(code(MEM, 1'b1), 1'b0);
        u_master.stop_cond();
        wait_idle();
        `CHK("busy length", PROG, busy_last);
        rd_at(MEM, 8'h40, 8'h5a);
    endtask : t_byte_write

    task automatic t_page;
        logic r;
        logic [7:0] a;
        u_master.start_cond();
        send(code(MEM, 1'b0), 1'b1);
        send(8'h14, 1'b1);
        for (int i = 0; i < 16; i++) send(8'h80 + i[7:0], 1'b1);
        u_master.stop_cond();
        wait_idle();
        u_master.start_cond();
        send(code(MEM, 1'b0), 1'b1);
        send(8'h10, 1'b1);
        u_master.start_cond();
        send(code(MEM, 1'b1), 1'b1);
        for (int i = 0; i < 15; i++) begin
            a = 8'h10 + i[7:0];
            recv(i != 14, {4'h8, a[3:0] - 4'h4});
        end
        u_master.bit_cycle(1'b1, r);
        `CHK("released after nack", 1'b1, r);
        u_master.stop_cond();
        u_master.start_cond();
        send(code(MEM, 1'b1), 1'b1);
        recv(1'b0, 8'h8b);
        u_master.stop_cond();
    endtask : t_page

    task automatic t_refuse;
        u_master.start_cond();
        send({4'h9, STRAP, 1'b0}, 1'b0);
        u_master.stop_cond();
        u_master.start_cond();
        send({MEM, STRAP ^ 3'h1, 1'b1}, 1'b0);
        u_master.stop_cond();
        @(posedge i_clk);
        #1;
        i_wc_n = 1'b1;
        u_master.start_cond();
        send(code(MEM, 1'b0), 1'b1);
        send(8'h40, 1'b1);
        send(8'ha5, 1'b0);
        u_master.stop_cond();
        repeat (4) @(posedge i_clk);
        `CHK("busy after refused write", 1'b0, o_busy);
        rd_at(MEM, 8'h40, 8'h5a);
        @(posedge i_clk);
        #1;
        i_wc_n = 1'b0;
    endtask : t_refuse

    task automatic end_sim;
        if (error_cnt == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (80000) @(posedge i_clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        i_rst     = 1'b1;
        i_wc_n    = 1'b0;
        strap     = STRAP;
        error_cnt = 0;
        checks    = 0;
        busy_run  = 0;
        busy_last = 0;
        repeat (16) @(posedge i_clk);
        #1;
        `CHK("oe_n in reset", 1'b1, o_sda_oe_n);
        `CHK("busy in reset", 1'b0, o_busy);
        `CHK("sda drive level", 1'b0, o_sda);
        i_rst = 1'b0;
        repeat (8) @(posedge i_clk);
        t_prot();
        t_byte_write();
        t_page();
        t_refuse();
        end_sim();
    end
endmodule : presence_detect_eeprom_slave_bench

`default_nettype wire
